// File: verilog/ccp_pkg.sv
// constants, codes and register map of the capture/compare/pwm control block
package ccp_pkg;

  // register map, word index on the plain register port
  localparam int unsigned CCP_ADDR_W     = 3;
  localparam int unsigned CCP_DATA_W     = 8;
  localparam logic [2:0]  CCP_OFF_CTRL   = 3'h0;
  localparam logic [2:0]  CCP_OFF_VAL_LO = 3'h1;
  localparam logic [2:0]  CCP_OFF_VAL_HI = 3'h2;
  localparam logic [2:0]  CCP_OFF_STATUS = 3'h3;
  localparam logic [2:0]  CCP_OFF_PIN    = 3'h4;

  // reset values
  localparam logic [7:0]  CCP_CTRL_RST   = 8'h00;
  localparam logic [15:0] CCP_VAL_RST    = 16'h0000;
  localparam logic [7:0]  CCP_PIN_RST    = 8'h01;

  // unit_control field positions
  localparam int unsigned CCP_MODE_LSB   = 0;
  localparam int unsigned CCP_DUTY_LSB   = 4;
  localparam int unsigned CCP_STEER_LSB  = 6;

  // status and pin register bit positions
  localparam int unsigned CCP_FLAG_BIT   = 0;
  localparam int unsigned CCP_DIR_BIT    = 0;
  localparam int unsigned CCP_LATCH_BIT  = 1;
  localparam int unsigned CCP_PINLVL_BIT = 2;

  // mode_select codes
  localparam logic [3:0]  CCP_M_OFF      = 4'h0;
  localparam logic [3:0]  CCP_M_TOGGLE   = 4'h2;
  localparam logic [3:0]  CCP_M_CAP_FALL = 4'h4;
  localparam logic [3:0]  CCP_M_CAP_RISE = 4'h5;
  localparam logic [3:0]  CCP_M_CAP_4    = 4'h6;
  localparam logic [3:0]  CCP_M_CAP_16   = 4'h7;
  localparam logic [3:0]  CCP_M_SET      = 4'h8;
  localparam logic [3:0]  CCP_M_CLEAR    = 4'h9;
  localparam logic [3:0]  CCP_M_SOFT     = 4'hA;
  localparam logic [3:0]  CCP_M_SPECIAL  = 4'hB;

  // output_steering codes in pwm
  localparam logic [1:0]  CCP_ST_SINGLE  = 2'h0;
  localparam logic [1:0]  CCP_ST_FWD     = 2'h1;
  localparam logic [1:0]  CCP_ST_HALF    = 2'h2;
  localparam logic [1:0]  CCP_ST_REV     = 2'h3;

  // capture prescaler
  localparam logic [3:0]  CCP_PRE_RST    = 4'h0;
  localparam logic [1:0]  CCP_PRE4_LAST  = 2'h3;
  localparam logic [3:0]  CCP_PRE16_LAST = 4'hF;

  // class of operation, gray along off -> capture -> compare -> pwm
  typedef enum logic [1:0] {
    CCP_CL_OFF     = 2'b00,
    CCP_CL_CAPTURE = 2'b01,
    CCP_CL_COMPARE = 2'b11,
    CCP_CL_PWM     = 2'b10
  } ccp_class_t;

endpackage : ccp_pkg

// File: verilog/ccp_sync.sv
// two flip-flop synchroniser for levels arriving from pins
`timescale 1ns/1ps
`default_nettype none
module ccp_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : ccp_sync
`default_nettype wire

// File: verilog/ccp_pwm.sv
// pwm duty generator with double-buffered 10-bit duty on the second timer base
`timescale 1ns/1ps
`default_nettype none
module ccp_pwm #(
  parameter int unsigned DUTY_W = 10
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              enable,
  input  wire logic              period_match,
  input  wire logic [DUTY_W-1:0] time_base,
  input  wire logic [DUTY_W-1:0] duty,
  output logic                   pwm_level,
  output logic      [DUTY_W-1:0] duty_latched
);

  logic [DUTY_W-1:0] duty_q, duty_d;
  logic              lvl_q, lvl_d;

  // duty only takes effect at a period boundary, which keeps edges glitch free
  always_comb begin
    duty_d = duty_q;
    lvl_d  = lvl_q;
    if (!enable) begin
      duty_d = '0;
      lvl_d  = 1'b0;
    end else if (period_match) begin
      duty_d = duty;
      lvl_d  = (duty != '0);
    end else if (time_base == duty_q) begin
      lvl_d  = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      duty_q <= '0;
      lvl_q  <= 1'b0;
    end else begin
      duty_q <= duty_d;
      lvl_q  <= lvl_d;
    end
  end

  assign pwm_level    = lvl_q;
  assign duty_latched = duty_q;

endmodule : ccp_pwm
`default_nettype wire

// File: verilog/ccp_top.sv
// capture/compare/pwm control unit with register port and four steered outputs
//
// What this block does
// - mode 0000 switches unit off, resets state
// - code 0010 toggles output, flags each match
// - codes 0100-0111 pick capture edge and prescale
// - codes 1000/1001 set/clear output, flag match
// - code 1010 flags only, pin untouched
// - code 1011 flags, resets timer, starts conversion
// - pwm code bits 1,0 invert A/C, B/D
// - non-pwm: steering ignored, only A used
// - steering 00 single A, 10 half-bridge A/B
// - steering 01 forward on D, 11 reverse on B
// - duty_low_bits extend duty only in pwm
// - capture copies 16-bit first timer count
// - captures set flag; only software clears it
// - newer capture overwrites unread held value
// - output-direction port write can cause capture
// - capture/compare use timer one, pwm timer two
// - prescaler cleared when off or not capturing
// - compare value checked continuously against timer
////////////////////////////////////////////////////////////////////////////////
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module ccp_top #(
  parameter int unsigned TIMER_W = 16,
  parameter int unsigned DUTY_W  = 10
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  input  wire logic [ccp_pkg::CCP_ADDR_W-1:0] reg_addr,
  input  wire logic [ccp_pkg::CCP_DATA_W-1:0] reg_wdata,
  input  wire logic                         reg_write,
  input  wire logic                         reg_read,
  output logic      [ccp_pkg::CCP_DATA_W-1:0] reg_rdata,
  input  wire logic [TIMER_W-1:0]           first_timer_count,
  input  wire logic [DUTY_W-1:0]            second_timer_base,
  input  wire logic                         second_timer_period_match,
  input  wire logic                         adc_enable,
  input  wire logic                         capture_compare_pin,
  output logic                              output_a,
  output logic                              output_a_oe,
  output logic                              output_b,
  output logic                              output_b_oe,
  output logic                              output_c,
  output logic                              output_c_oe,
  output logic                              output_d,
  output logic                              output_d_oe,
  output logic                              match_capture_flag,
  output logic                              first_timer_reset,
  output logic                              adc_start
);
  import ccp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]         ctrl_q, ctrl_d;
  logic [TIMER_W-1:0] val_q, val_d;
  logic [7:0]         pin_q, pin_d;
  logic               flag_q, flag_d;
  logic               src_prev_q, src_prev_d;
  logic [3:0]         pre_q, pre_d;
  logic               hit_prev_q, hit_prev_d;
  logic               cmp_q, cmp_d;
  logic               t1rst_q, t1rst_d;
  logic               adc_q, adc_d;
  logic [7:0]         rdata_q, rdata_d;
  logic [3:0]         out_q, out_d;
  logic [3:0]         oe_q, oe_d;

  logic [3:0]         mode;
  logic [1:0]         steer;
  ccp_class_t         cls;
  logic               pin_sync;
  logic               src, rise, fall;
  logic               cap_ev, cmp_eq, cmp_hit, sw_clear;
  logic               pwm_level;
  logic [DUTY_W-1:0]  duty_latched;
  logic [DUTY_W-1:0]  duty;
  logic [3:0]         lvl, act_oe;

  assign mode  = ctrl_q[CCP_MODE_LSB +: 4];
  assign steer = ctrl_q[CCP_STEER_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////////
  // mode decode; reserved codes fall back to off
  always_comb begin
    case (mode[3:2])
      2'b00:   cls = (mode == CCP_M_TOGGLE) ? CCP_CL_COMPARE : CCP_CL_OFF;
      2'b01:   cls = CCP_CL_CAPTURE;
      2'b10:   cls = CCP_CL_COMPARE;
      default: cls = CCP_CL_PWM;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin input crossing
  ccp_sync #(
    .WIDTH (1)
  ) u_pin_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (capture_compare_pin),
    .sync_out (pin_sync)
  );

  // with the pin set as output the port latch is what the pin carries
  assign src  = pin_q[CCP_DIR_BIT] ? pin_sync : pin_q[CCP_LATCH_BIT];
  assign rise = src & ~src_prev_q;
  assign fall = ~src & src_prev_q;

  // capture event per mode; the prescaler counts rising edges mod 16
  always_comb begin
    cap_ev = 1'b0;
    if (cls == CCP_CL_CAPTURE) begin
      case (mode)
        CCP_M_CAP_FALL: cap_ev = fall;
        CCP_M_CAP_RISE: cap_ev = rise;
        CCP_M_CAP_4:    cap_ev = rise && (pre_q[1:0] == CCP_PRE4_LAST);
        default:        cap_ev = rise && (pre_q == CCP_PRE16_LAST);
      endcase
    end
  end

  // compare uses first timer; a held match acts only once
  assign cmp_eq  = (cls == CCP_CL_COMPARE) && (first_timer_count == val_q);
  assign cmp_hit = cmp_eq && !hit_prev_q;

  assign sw_clear = reg_write && (reg_addr == CCP_OFF_STATUS) && reg_wdata[CCP_FLAG_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // pwm engine on the second timer
  assign duty = {val_q[7:0], ctrl_q[CCP_DUTY_LSB +: 2]};

  ccp_pwm #(
    .DUTY_W (DUTY_W)
  ) u_pwm (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .enable       (cls == CCP_CL_PWM),
    .period_match (second_timer_period_match),
    .time_base    (second_timer_base),
    .duty         (duty),
    .pwm_level    (pwm_level),
    .duty_latched (duty_latched)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // registers, capture, compare and flag
  always_comb begin
    ctrl_d     = ctrl_q;
    val_d      = val_q;
    pin_d      = pin_q;
    src_prev_d = src;
    hit_prev_d = cmp_eq;
    pre_d      = pre_q;
    cmp_d      = cmp_q;
    t1rst_d    = 1'b0;
    adc_d      = 1'b0;

    if (reg_write) begin
      if (reg_addr == CCP_OFF_CTRL) begin
        ctrl_d = reg_wdata;
      end else if (reg_addr == CCP_OFF_VAL_LO) begin
        val_d[7:0] = reg_wdata;
      end else if (reg_addr == CCP_OFF_VAL_HI && cls != CCP_CL_PWM) begin
        val_d[TIMER_W-1:8] = reg_wdata;
      end else if (reg_addr == CCP_OFF_PIN) begin
        pin_d[CCP_LATCH_BIT:CCP_DIR_BIT] = reg_wdata[CCP_LATCH_BIT:CCP_DIR_BIT];
      end
    end

    // a capture wins over a software write of the same cycle
    if (cap_ev) begin
      val_d = first_timer_count;
    end

    if (cls == CCP_CL_CAPTURE) begin
      if (rise) begin
        pre_d = pre_q + 4'h1;
      end
    end else begin
      pre_d = CCP_PRE_RST;
    end

    if (cmp_hit) begin
      case (mode)
        CCP_M_TOGGLE:  cmp_d = ~cmp_q;
        CCP_M_SET:     cmp_d = 1'b1;
        CCP_M_CLEAR:   cmp_d = 1'b0;
        CCP_M_SPECIAL: begin
          t1rst_d = 1'b1;
          adc_d   = adc_enable;
        end
        default:       cmp_d = cmp_q;
      endcase
    end

    // off drops the output latch, the prescaler and the match history
    if (cls == CCP_CL_OFF) begin
      cmp_d      = 1'b0;
      pre_d      = CCP_PRE_RST;
      hit_prev_d = 1'b0;
    end

    // the flag lives outside the unit, so switching off keeps it
    flag_d = cap_ev | cmp_hit | (flag_q & ~sw_clear);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output steering and polarity
  always_comb begin
    lvl    = 4'h0;
    act_oe = 4'h0;
    if (cls == CCP_CL_PWM) begin
      case (steer)
        CCP_ST_SINGLE: begin
          lvl    = {3'b000, pwm_level};
          act_oe = 4'b0001;
        end
        CCP_ST_FWD: begin
          lvl    = {pwm_level, 3'b001};
          act_oe = 4'b1111;
        end
        CCP_ST_HALF: begin
          // plain complement; dead-band delay is left to the bridge driver
          lvl    = {2'b00, ~pwm_level, pwm_level};
          act_oe = 4'b0011;
        end
        default: begin
          lvl    = {1'b0, 1'b1, pwm_level, 1'b0};
          act_oe = 4'b1111;
        end
      endcase
      // bit 1 inverts A and C, bit 0 inverts B and D
      out_d = lvl ^ {mode[0], mode[1], mode[0], mode[1]};
    end else begin
      // steering ignored; B to D stay with the port
      out_d  = {3'b000, cmp_q};
      act_oe[0] = (mode == CCP_M_TOGGLE) || (mode == CCP_M_SET) ||
                  (mode == CCP_M_CLEAR);
    end
    // the pin driver also needs the direction set to output
    oe_d = act_oe & {3'b111, ~pin_q[CCP_DIR_BIT]};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    if (reg_read) begin
      if (reg_addr == CCP_OFF_CTRL) begin
        rdata_d = ctrl_q;
      end else if (reg_addr == CCP_OFF_VAL_LO) begin
        rdata_d = val_q[7:0];
      end else if (reg_addr == CCP_OFF_VAL_HI) begin
        rdata_d = (cls == CCP_CL_PWM) ? duty_latched[DUTY_W-1:2] : val_q[TIMER_W-1:8];
      end else if (reg_addr == CCP_OFF_STATUS) begin
        rdata_d = {7'h00, flag_q};
      end else if (reg_addr == CCP_OFF_PIN) begin
        rdata_d = {5'h00, pin_sync, pin_q[CCP_LATCH_BIT:CCP_DIR_BIT]};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q     <= CCP_CTRL_RST;
      val_q      <= CCP_VAL_RST;
      pin_q      <= CCP_PIN_RST;
      flag_q     <= 1'b0;
      src_prev_q <= 1'b0;
      pre_q      <= CCP_PRE_RST;
      hit_prev_q <= 1'b0;
      cmp_q      <= 1'b0;
      t1rst_q    <= 1'b0;
      adc_q      <= 1'b0;
      rdata_q    <= 8'h00;
      out_q      <= 4'h0;
      oe_q       <= 4'h0;
    end else begin
      ctrl_q     <= ctrl_d;
      val_q      <= val_d;
      pin_q      <= pin_d;
      flag_q     <= flag_d;
      src_prev_q <= src_prev_d;
      pre_q      <= pre_d;
      hit_prev_q <= hit_prev_d;
      cmp_q      <= cmp_d;
      t1rst_q    <= t1rst_d;
      adc_q      <= adc_d;
      rdata_q    <= rdata_d;
      out_q      <= out_d;
      oe_q       <= oe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops
  assign reg_rdata          = rdata_q;
  assign output_a           = out_q[0];
  assign output_b           = out_q[1];
  assign output_c           = out_q[2];
  assign output_d           = out_q[3];
  assign output_a_oe        = oe_q[0];
  assign output_b_oe        = oe_q[1];
  assign output_c_oe        = oe_q[2];
  assign output_d_oe        = oe_q[3];
  assign match_capture_flag = flag_q;
  assign first_timer_reset  = t1rst_q;
  assign adc_start          = adc_q;

endmodule : ccp_top
`default_nettype wire

// File: dv/ccp_properties.sv
// concurrent checks on the ports of the capture/compare/pwm control block
`timescale 1ns/1ps
`default_nettype none
module ccp_checker
  import ccp_pkg::*;
#(
  parameter int unsigned TIMER_W = 16
) (
  input wire logic                           ref_clk,
  input wire logic                           rst,
  input wire logic [ccp_pkg::CCP_ADDR_W-1:0] reg_addr,
  input wire logic [ccp_pkg::CCP_DATA_W-1:0] reg_wdata,
  input wire logic                           reg_write,
  input wire logic                           reg_read,
  input wire logic [ccp_pkg::CCP_DATA_W-1:0] reg_rdata,
  input wire logic [TIMER_W-1:0]             first_timer_count,
  input wire logic                           adc_enable,
  input wire logic                           capture_compare_pin,
  input wire logic                           output_a,
  input wire logic                           output_a_oe,
  input wire logic                           output_b_oe,
  input wire logic                           output_c_oe,
  input wire logic                           output_d_oe,
  input wire logic                           match_capture_flag,
  input wire logic                           first_timer_reset,
  input wire logic                           adc_start
);
  // shadow of the control and compare value, tracked from bus writes
  logic [7:0]         ctrl_q, ctrl_d;
  logic [TIMER_W-1:0] val_q, val_d;
  logic               hit_q;
  logic               clr_q;
  wire logic [3:0]    mode = ctrl_q[3:0];
  wire logic          hit  = first_timer_count == val_q;
  wire logic          cmp  = mode inside {CCP_M_TOGGLE, CCP_M_SET, CCP_M_CLEAR, CCP_M_SOFT, CCP_M_SPECIAL};
  always_comb begin
    ctrl_d = ctrl_q;
    val_d  = val_q;
    if (reg_write && reg_addr == CCP_OFF_CTRL) ctrl_d = reg_wdata;
    if (reg_write && reg_addr == CCP_OFF_VAL_LO) val_d[7:0] = reg_wdata;
    if (reg_write && reg_addr == CCP_OFF_VAL_HI) val_d[15:8] = reg_wdata;
  end
  // hit_q starts high so an equality held through reset is not a new match
  always_ff @(posedge ref_clk) begin
    ctrl_q <= rst ? CCP_CTRL_RST : ctrl_d;
    val_q  <= rst ? CCP_VAL_RST : val_d;
    hit_q  <= rst | hit;
    clr_q  <= !rst && reg_write && reg_addr == CCP_OFF_STATUS && reg_wdata[CCP_FLAG_BIT];
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_new_match;
    hit && !hit_q;
  endsequence
  property p_special;
    (mode == CCP_M_SPECIAL) ##0 s_new_match |=> first_timer_reset && adc_start == $past(adc_enable);
  endproperty
  a_flag_sticky: assert property ($fell(match_capture_flag) |-> clr_q)
    else $error("flag dropped without a software clear");
  a_cap_event: assert property ((mode == CCP_M_CAP_RISE && $rose(capture_compare_pin)) |-> ##[1:5] match_capture_flag)
    else $error("rising pin edge gave no capture");
  a_cmp_flag: assert property (cmp ##0 s_new_match |=> match_capture_flag)
    else $error("compare match did not set flag");
  a_special_trig: assert property (p_special)
    else $error("special event missing timer reset or conversion start");
  a_trig_cause: assert property (first_timer_reset |-> $past(mode) == CCP_M_SPECIAL)
    else $error("timer reset outside special event mode");
  a_adc_cause: assert property (adc_start |-> first_timer_reset && $past(adc_enable))
    else $error("conversion start without enabled special event");
  a_toggle_out: assert property ((mode == CCP_M_TOGGLE) ##0 s_new_match |-> ##2 output_a != $past(output_a))
    else $error("toggle mode did not invert output");
  a_set_clear: assert property ((mode == CCP_M_SET || mode == CCP_M_CLEAR) ##0 s_new_match |-> ##2 output_a == !mode[0])
    else $error("set or clear mode drove wrong level");
  a_soft_quiet: assert property ((mode == CCP_M_SOFT || mode == CCP_M_SPECIAL) [*3] |-> !output_a_oe)
    else $error("pin driven in a flag only mode");
  a_steer_ignored: assert property ((mode[3:2] != 2'b11) [*3] |-> !(output_b_oe || output_c_oe || output_d_oe))
    else $error("extra outputs driven outside pwm");
  a_off_quiet: assert property ((mode == CCP_M_OFF) [*3] |-> !(output_a_oe || output_a || first_timer_reset || adc_start))
    else $error("unit active while off");
endmodule : ccp_checker
`default_nettype wire

// File: dv/ccp_edge_src.sv
// external event source: drives the capture pin with timed pulses
`timescale 1ns/1ps
`default_nettype none
module ccp_edge_src #(
  parameter int unsigned HIGH_CYC = 4
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic fire,
  output logic      pin_level
);
  logic [3:0] cnt_q, cnt_d;
  always_comb begin
    cnt_d = cnt_q;
    if (fire) cnt_d = 4'(HIGH_CYC);
    else if (cnt_q != 4'h0) cnt_d = cnt_q - 4'h1;
  end
  always_ff @(posedge ref_clk) begin
    cnt_q <= rst ? 4'h0 : cnt_d;
  end
  // pin rests low between pulses, so each pulse is one rising and one falling edge
  assign pin_level = cnt_q != 4'h0;
endmodule : ccp_edge_src
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench for the capture/compare/pwm control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ccp_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  reg_addr = 3'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [7:0]  reg_rdata;
  logic [15:0] first_timer_count = 16'h0000;
  logic        second_timer_period_match = 1'b0;
  logic        adc_enable = 1'b1;
  logic        fire = 1'b0;
  logic        capture_compare_pin;
  logic        output_a, output_a_oe, output_b, output_b_oe, output_c, output_c_oe, output_d, output_d_oe;
  logic        match_capture_flag, first_timer_reset, adc_start;
  logic [1:0]  r;
  logic        exp_lvl;
  int          errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          n_trig = 0;
  int          n_adc = 0;
  logic [3:0]  cap_m [4] = '{CCP_M_CAP_FALL, CCP_M_CAP_RISE, CCP_M_CAP_4, CCP_M_CAP_16};
  int          cap_n [4] = '{1, 1, 4, 16};
  // the second special event pass runs with the converter disabled
  logic [3:0]  cmp_m [6] = '{CCP_M_TOGGLE, CCP_M_SET, CCP_M_CLEAR, CCP_M_SOFT, CCP_M_SPECIAL, CCP_M_SPECIAL};
  // per steering, roles of a,b,c,d: 0 port pin, 1 modulated, 2 active, 3 inactive
  logic [7:0]  roles [4] = '{8'h40, 8'hBD, 8'h50, 8'hDB};
  wire logic [3:0] outs = {output_a, output_b, output_c, output_d};
  wire logic [3:0] oes  = {output_a_oe, output_b_oe, output_c_oe, output_d_oe};

  always #10 ref_clk = ~ref_clk;

  ccp_top dut_u (
    .ref_clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .first_timer_count,
    .second_timer_base(10'h000), .second_timer_period_match, .adc_enable, .capture_compare_pin,
    .output_a, .output_a_oe, .output_b, .output_b_oe, .output_c, .output_c_oe, .output_d, .output_d_oe,
    .match_capture_flag, .first_timer_reset, .adc_start
  );
  ccp_edge_src src_u (.ref_clk, .rst, .fire, .pin_level(capture_compare_pin));
  ////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : idle
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe; sampled there once settled
  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string n);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1;
    chk(n, reg_rdata, exp);
  endtask : rd
  task automatic pulse(input logic [15:0] t);
    @(posedge ref_clk);
    first_timer_count <= t;
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    idle(12);
  endtask : pulse
  ////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    cycles++;
    if (first_timer_reset === 1'b1) n_trig++;
    if (adc_start === 1'b1) n_adc++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rd(CCP_OFF_CTRL, CCP_CTRL_RST, "ctrl_reset");
    rd(CCP_OFF_VAL_HI, CCP_VAL_RST[15:8], "value_reset");
    rd(CCP_OFF_PIN, CCP_PIN_RST, "pin_reset");
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'h00, "unmapped");
    wr(CCP_OFF_CTRL, 8'h3A);
    rd(CCP_OFF_CTRL, 8'h3A, "ctrl_rw");
    // reserved mode codes are never written
    // pin stays an input from reset for capture
    for (int k = 0; k < 4; k++) begin
      // one extra edge leaves the prescaler odd, so only the off write can realign it
      pulse(16'h0000);
      wr(CCP_OFF_CTRL, 8'h00);
      wr(CCP_OFF_CTRL, {4'h0, cap_m[k]});
      wr(CCP_OFF_STATUS, 8'h01);
      for (int i = 1; i <= 16; i++) begin
        pulse(16'h0A00 + 16'(i));
        rd(CCP_OFF_STATUS, {7'h00, i >= cap_n[k]}, "cap_flag");
        if (i == cap_n[k]) rd(CCP_OFF_VAL_LO, 8'(i), "cap_lo");
      end
      rd(CCP_OFF_VAL_LO, 8'h10, "cap_newest");
      rd(CCP_OFF_VAL_HI, 8'h0A, "cap_hi");
    end
    wr(CCP_OFF_CTRL, {4'h0, CCP_M_CAP_RISE});
    wr(CCP_OFF_PIN, 8'h00);
    wr(CCP_OFF_STATUS, 8'h01);
    first_timer_count <= 16'h5A5A;
    wr(CCP_OFF_PIN, 8'h02);
    idle(6);
    rd(CCP_OFF_VAL_HI, 8'h5A, "latch_cap");
    for (int k = 0; k < 6; k++) begin
      wr(CCP_OFF_CTRL, 8'h00);
      first_timer_count <= 16'h0000;
      adc_enable        <= (k != 5);
      wr(CCP_OFF_VAL_LO, 8'h40);
      wr(CCP_OFF_VAL_HI, 8'h01);
      wr(CCP_OFF_CTRL, {4'h3, cmp_m[k]});
      n_trig = 0;
      n_adc = 0;
      // the first equal cycle meets a flag clear, which must lose;
      // equality held four cycles must still count as one match
      @(posedge ref_clk);
      reg_addr          <= CCP_OFF_STATUS;
      reg_wdata         <= 8'h01;
      reg_write         <= 1'b1;
      first_timer_count <= 16'h0140;
      @(posedge ref_clk);
      reg_write <= 1'b0;
      repeat (3) @(posedge ref_clk);
      first_timer_count <= 16'h0141;
      idle(4);
      rd(CCP_OFF_STATUS, 8'h01, "cmp_flag");
      chk("trig", 16'(n_trig), 16'(cmp_m[k] == CCP_M_SPECIAL));
      chk("adc", 16'(n_adc), 16'(cmp_m[k] == CCP_M_SPECIAL && k != 5));
      chk("cmp_oe", output_a_oe, cmp_m[k] < CCP_M_SOFT);
      if (cmp_m[k] < CCP_M_SOFT) chk("cmp_out", output_a, cmp_m[k] != CCP_M_CLEAR);
    end
    wr(CCP_OFF_CTRL, 8'h00);
    wr(CCP_OFF_VAL_LO, 8'hFF);
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < 4; p++) begin
        wr(CCP_OFF_CTRL, {2'(s), 2'h3, 2'h3, 2'(p)});
        @(posedge ref_clk);
        second_timer_period_match <= 1'b1;
        @(posedge ref_clk);
        second_timer_period_match <= 1'b0;
        idle(4);
        for (int j = 0; j < 4; j++) begin
          r = roles[s][7-2*j -: 2];
          chk("pwm_oe", oes[3-j], r != 2'h0);
          // half-bridge b is the complement of a
          exp_lvl = ((r != 2'h3) && !(s == 2 && j == 1)) ^ (j[0] ? p[0] : p[1]);
          if (r != 2'h0) chk("pwm_out", outs[3-j], exp_lvl);
        end
      end
    end
    wr(CCP_OFF_VAL_HI, 8'h00);
    rd(CCP_OFF_VAL_HI, 8'hFF, "duty_hi");
    wr(CCP_OFF_CTRL, 8'h00);
    idle(4);
    chk("off_oe", oes, 4'h0);
    stop_test();
  end
endmodule : tb_top

bind ccp_top ccp_checker #(.TIMER_W(TIMER_W)) chk_u (
  .ref_clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .first_timer_count, .adc_enable,
  .capture_compare_pin, .output_a, .output_a_oe, .output_b_oe, .output_c_oe, .output_d_oe,
  .match_capture_flag, .first_timer_reset, .adc_start
);
`default_nettype wire
